// *** pas_consts.svh ***
// Constants for the pipelined converter sample output block.
// Assumes a 25 MHz system clock; included by pas_pkg.sv and pas_top.sv.
`ifndef PAS_CONSTS_SVH
`define PAS_CONSTS_SVH

`define PAS_CLK_PERIOD_NS   40
`define PAS_RESULT_W        12
`define PAS_AIN_W           16
`define PAS_VREF_W          16
`define PAS_FIFO_DEPTH      8
`define PAS_FIFO_AW         3
`define PAS_LATENCY_EDGES   4'h3
`define PAS_SYNC_CYCLES     2
`define PAS_CONV_TIME_NS    150
`define PAS_CONV_CYCLES     (`PAS_CONV_TIME_NS / `PAS_CLK_PERIOD_NS)
`define PAS_UPDATE_CYCLES   ((`PAS_CONV_CYCLES > `PAS_SYNC_CYCLES + 1) ? \
                             (`PAS_CONV_CYCLES - `PAS_SYNC_CYCLES) : 1)
`define PAS_IDLE_TIME_NS    1000000
`define PAS_IDLE_CYCLES     (`PAS_IDLE_TIME_NS / `PAS_CLK_PERIOD_NS)
`define PAS_IDLE_W          20
`define PAS_VREF_HIGH       16'h4000
`define PAS_VREF_LOW        16'h2000
`define PAS_CODE_MAX        12'h7ff
`define PAS_CODE_MIN        12'h800
`define PAS_SCALE_SHIFT     12

`endif

// *** pas_pkg.sv ***
// Types for the pipelined converter sample output block.
// Assumes pas_consts.svh is on the include path.
`default_nettype none
`include "pas_consts.svh"

package pas_pkg;
  // Reference strap decode
  typedef enum logic [1:0] {
    PAS_REF_GROUND   = 2'h0,
    PAS_REF_TO_VREF  = 2'h1,
    PAS_REF_EXTERNAL = 2'h2,
    PAS_REF_SPARE    = 2'h3
  } pas_ref_mode_t;

  // Output update sequencer, one-hot
  typedef enum logic [1:0] {
    PAS_ST_IDLE = 2'b01,
    PAS_ST_WAIT = 2'b10
  } pas_state_t;
endpackage

`default_nettype wire

// *** pas_top.sv ***
// Digital side of a pipelined 12-bit sampling converter plus its result FIFO.
// Assumes conversion clock, straps and sampled analog words arrive from outside
// the system clock domain; all are passed through two flip-flops first.
`default_nettype none
`include "pas_consts.svh"

// Result buffer: flip-flop storage, valid/ready on both sides
module pas_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = `PAS_FIFO_DEPTH,
  parameter int AW    = `PAS_FIFO_AW
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [AW:0]      level
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (count_q != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];
  assign level     = count_q;

  // Storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Write pointer wraps naturally since depth is a power of two
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + AW'(1);
    end
  end

  // Read pointer, same natural wrap
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + AW'(1);
    end
  end

  // Occupancy; a push and a pop in one cycle leave it unchanged
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Behaviour
// - a rising conversion clock edge starts a new conversion; clock is active high.
// - both analog inputs are captured at the same edge into the pipeline.
// - result updates ~150ns after second next start; latch on third edge.
// - a new sample is taken on every edge; one result per cycle.
// - result is a 12-bit two's complement word, MSB on bit 11.
// - out-of-range flag high exactly for full-scale positive or negative codes.
// - gain strap high gives unity gain, low gives double gain.
// - after 1ms without a clock edge an internal refresh timer runs.
// - reference strap picks 4.096V, 2.048V, or an external reference.
// - a started conversion always completes; later edges neither abort nor restart it.
// - only the rising clock edge times internal activity; duty cycle is free.
module pas_top #(
  parameter int IDLE_CYCLES = `PAS_IDLE_CYCLES
) (
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  input  wire logic                          conv_clk,
  input  wire logic signed [`PAS_AIN_W-1:0]  ain_pos,
  input  wire logic signed [`PAS_AIN_W-1:0]  ain_neg,
  input  wire logic                          input_gain_stage,
  input  wire logic        [1:0]             ref_mode,
  input  wire logic        [`PAS_VREF_W-1:0] ext_ref,
  output logic             [`PAS_RESULT_W-1:0] result_bits,
  output logic                               out_of_range_flag,
  output logic                               refresh_tick,
  output logic                               sample_dropped
);
  localparam int RW = `PAS_RESULT_W;

  // Two-stage synchronisers; only stage two is read by logic
  logic                   clk_s1_q;
  logic                   clk_s2_q;
  logic                   clk_last_q;
  logic signed [`PAS_AIN_W-1:0] pos_s1_q;
  logic signed [`PAS_AIN_W-1:0] pos_s2_q;
  logic signed [`PAS_AIN_W-1:0] neg_s1_q;
  logic signed [`PAS_AIN_W-1:0] neg_s2_q;
  logic                   gain_s1_q;
  logic                   gain_s2_q;
  logic [1:0]             ref_s1_q;
  logic [1:0]             ref_s2_q;
  logic [`PAS_VREF_W-1:0] ext_s1_q;
  logic [`PAS_VREF_W-1:0] ext_s2_q;

  // Conversion clock pin and the previous stage-two value for edge detection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_s1_q   <= 1'b0;
      clk_s2_q   <= 1'b0;
      clk_last_q <= 1'b0;
    end else begin
      clk_s1_q   <= conv_clk;
      clk_s2_q   <= clk_s1_q;
      clk_last_q <= clk_s2_q;
    end
  end

  // Analog words; same depth as the clock path so sample and edge line up
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pos_s1_q <= '0;
      pos_s2_q <= '0;
      neg_s1_q <= '0;
      neg_s2_q <= '0;
    end else begin
      pos_s1_q <= ain_pos;
      pos_s2_q <= pos_s1_q;
      neg_s1_q <= ain_neg;
      neg_s2_q <= neg_s1_q;
    end
  end

  // Straps and external reference; gain comes out of reset at unity
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gain_s1_q <= 1'b1;
      gain_s2_q <= 1'b1;
      ref_s1_q  <= 2'h0;
      ref_s2_q  <= 2'h0;
      ext_s1_q  <= '0;
      ext_s2_q  <= '0;
    end else begin
      gain_s1_q <= input_gain_stage;
      gain_s2_q <= gain_s1_q;
      ref_s1_q  <= ref_mode;
      ref_s2_q  <= ref_s1_q;
      ext_s1_q  <= ext_ref;
      ext_s2_q  <= ext_s1_q;
    end
  end

  // Falling edges are deliberately ignored, so duty cycle does not matter
  logic conv_start;
  assign conv_start = clk_s2_q && !clk_last_q;

  // Reference selection from the strap
  logic [`PAS_VREF_W-1:0] vref;
  always_comb begin
    case (pas_pkg::pas_ref_mode_t'(ref_s2_q))
      pas_pkg::PAS_REF_GROUND:  vref = `PAS_VREF_HIGH;
      pas_pkg::PAS_REF_TO_VREF: vref = `PAS_VREF_LOW;
      default:                  vref = ext_s2_q;
    endcase
  end

  // Quantise the differential sample; external reference of zero pins to full scale
  logic signed [`PAS_AIN_W:0] diff;
  logic signed [29:0]         scaled;
  logic signed [29:0]         quot;
  logic [RW-1:0]              code;
  always_comb begin
    diff   = 17'(pos_s2_q) - 17'(neg_s2_q);
    scaled = 30'(diff) <<< (`PAS_SCALE_SHIFT + (gain_s2_q ? 0 : 1));
    if (vref == '0) begin
      quot = scaled[29] ? -30'sd2048 : 30'sd2047;
    end else begin
      quot = scaled / $signed({14'h0, vref});
    end
    if (quot > 30'sd2047) begin
      code = `PAS_CODE_MAX;
    end else if (quot < -30'sd2048) begin
      code = `PAS_CODE_MIN;
    end else begin
      code = quot[RW-1:0];
    end
  end

  // Flag travels with its word through the pipeline buffer
  logic          ovr;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic          pop_now;
  logic [RW:0]   fifo_out_data;
  logic [3:0]    fifo_level;
  assign ovr = (code == `PAS_CODE_MAX) || (code == `PAS_CODE_MIN);

  // Every edge pushes a fresh sample; earlier ones stay queued ahead of it
  pas_fifo #(
    .WIDTH (RW + 1),
    .DEPTH (`PAS_FIFO_DEPTH),
    .AW    (`PAS_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (conv_start),
    .in_ready  (fifo_in_ready),
    .in_data   ({ovr, code}),
    .out_valid (fifo_out_valid),
    .out_ready (pop_now),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Full buffer cannot happen at legal rates; a refused sample is reported
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sample_dropped <= 1'b0;
    end else begin
      sample_dropped <= conv_start && !fifo_in_ready;
    end
  end

  // Update sequencer: a pending update is never restarted by a later edge
  pas_pkg::pas_state_t state_q;
  logic [3:0]          wait_q;
  logic                update_due;
  assign update_due = (state_q == pas_pkg::PAS_ST_WAIT) && (wait_q == 4'h1);
  assign pop_now    = update_due && fifo_out_valid && (fifo_level >= `PAS_LATENCY_EDGES);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= pas_pkg::PAS_ST_IDLE;
      wait_q  <= 4'h0;
    end else begin
      case (state_q)
        pas_pkg::PAS_ST_IDLE: begin
          if (conv_start) begin
            state_q <= pas_pkg::PAS_ST_WAIT;
            wait_q  <= 4'(`PAS_UPDATE_CYCLES);
          end
        end
        pas_pkg::PAS_ST_WAIT: begin
          if (wait_q == 4'h1) begin
            state_q <= pas_pkg::PAS_ST_IDLE;
          end else begin
            wait_q <= wait_q - 4'h1;
          end
        end
        default: begin
          state_q <= pas_pkg::PAS_ST_IDLE;
        end
      endcase
    end
  end

  // Word and flag load in one register so both latch on the same edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result_bits       <= '0;
      out_of_range_flag <= 1'b0;
    end else if (pop_now) begin
      result_bits       <= fifo_out_data[RW-1:0];
      out_of_range_flag <= fifo_out_data[RW];
    end
  end

  // Idle watchdog: repeats a refresh pulse each period with no edge
  logic [`PAS_IDLE_W-1:0] idle_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idle_q       <= '0;
      refresh_tick <= 1'b0;
    end else if (conv_start) begin
      idle_q       <= '0;
      refresh_tick <= 1'b0;
    end else if (idle_q == `PAS_IDLE_W'(IDLE_CYCLES - 1)) begin
      idle_q       <= '0;
      refresh_tick <= 1'b1;
    end else begin
      idle_q       <= idle_q + `PAS_IDLE_W'(1);
      refresh_tick <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// *** pas_top_chk.sv ***
// Port checker for the converter top, bound at the foot.
// Assumes a legal conversion rate on the pin.
`default_nettype none
module pas_top_chk #(parameter int IDLE_CYCLES = 25000) (
  input wire logic               clock,
  input wire logic               reset_n,
  input wire logic               conv_clk,
  input wire logic signed [15:0] ain_pos,
  input wire logic signed [15:0] ain_neg,
  input wire logic               input_gain_stage,
  input wire logic        [1:0]  ref_mode,
  input wire logic        [15:0] ext_ref,
  input wire logic        [11:0] result_bits,
  input wire logic               out_of_range_flag,
  input wire logic               refresh_tick,
  input wire logic               sample_dropped
);
  logic [20:0] since_q;
  logic        prev_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Cycles since the pin rose; saturates so long stops never wrap
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      since_q <= 21'h0;
      prev_q  <= 1'b0;
    end else begin
      prev_q <= conv_clk;
      if (conv_clk && !prev_q) since_q <= 21'h0;
      else if (since_q != 21'h1fffff) since_q <= since_q + 21'h1;
    end
  end
  flag_exact_a: assert property (
    out_of_range_flag == (result_bits == 12'h7ff || result_bits == 12'h800)) else $error("flag");
  flag_word_a: assert property (
    $changed(out_of_range_flag) |-> $changed(result_bits)) else $error("flag alone");
  update_time_a: assert property (
    $changed(result_bits) |-> since_q inside {[21'h1:21'h6]}) else $error("update time");
  update_gap_a: assert property (
    $changed(result_bits) |=> $stable(result_bits) [*4]) else $error("update gap");
  no_drop_a: assert property (!sample_dropped) else $error("dropped");
  tick_idle_a: assert property (
    refresh_tick |-> since_q + 21'h2 >= IDLE_CYCLES) else $error("early refresh");
  tick_pulse_a: assert property (refresh_tick |=> !refresh_tick) else $error("long tick");
  reset_vals_a: assert property (
    $rose(reset_n) |-> result_bits == 12'h0 && !out_of_range_flag && !refresh_tick)
    else $error("reset state");
endmodule

bind pas_top pas_top_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_pas_top_chk (.clock, .reset_n,
  .conv_clk, .ain_pos, .ain_neg, .input_gain_stage, .ref_mode, .ext_ref, .result_bits,
  .out_of_range_flag, .refresh_tick, .sample_dropped);
`default_nettype wire

// *** pas_capture_model.sv ***
// Capture-side model: clocks conversions, latches each result.
// Assumes the bench clock; pins change at its falling edge.
`default_nettype none
module pas_capture_model (
  input  wire logic        clock,
  input  wire logic        run,
  input  wire logic [7:0]  hi_cyc,
  input  wire logic [7:0]  lo_cyc,
  input  wire logic [11:0] result_bits,
  input  wire logic        out_of_range_flag,
  output var  logic        conv_clk,
  output var  logic [11:0] cap_word,
  output var  logic        cap_flag,
  output var  logic [15:0] n_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  // Low phase first, so inputs settle before each rise
  initial begin
    conv_clk = 1'b0;
    n_edges = 16'h0;
    cap_word = 12'h0;
    cap_flag = 1'b0;
    forever begin
      @(negedge clock);
      if (run) begin
        repeat (lo_cyc - 8'h1) @(negedge clock);
        cap_word = result_bits;
        cap_flag = out_of_range_flag;
        conv_clk = 1'b1;
        n_edges = n_edges + 16'h1;
        repeat (hi_cyc) @(negedge clock);
        conv_clk = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** test_pipelined_adc_sample_output.sv ***
// Self-checking bench for the converter top and its capture model.
// Assumes both are compiled first.
`default_nettype none
module test_pipelined_adc_sample_output;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock = 1'b0;
  logic               reset_n = 1'b0;
  logic               run = 1'b0;
  logic               input_gain_stage = 1'b1;
  logic        [1:0]  ref_mode = 2'h0;
  logic        [7:0]  hi_cyc = 8'h3;
  logic        [7:0]  lo_cyc = 8'h3;
  logic signed [15:0] ain_pos = 16'h0;
  logic signed [15:0] ain_neg = 16'h0;
  logic        [15:0] ext_ref = 16'h1000;
  logic        [11:0] result_bits, cap_word;
  logic        [15:0] n_edges;
  logic               conv_clk, out_of_range_flag, cap_flag, refresh_tick, sample_dropped;
  int                 n_errors = 0;
  int                 compares = 0;
  int                 seen = 0;
  int                 ticks;
  int                 exp_q[$];
  int                 grp_q[$];

  always #20 clock = ~clock;

  pas_top #(.IDLE_CYCLES(50)) u_pas_top (.clock, .reset_n, .conv_clk, .ain_pos, .ain_neg,
    .input_gain_stage, .ref_mode, .ext_ref, .result_bits, .out_of_range_flag, .refresh_tick,
    .sample_dropped);
  pas_capture_model u_pas_capture_model (.clock, .run, .hi_cyc, .lo_cyc, .result_bits,
    .out_of_range_flag, .conv_clk, .cap_word, .cap_flag, .n_edges);

  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic bad(input string msg);
    n_errors++;
    $display("BAD %0t %s", $time, msg);
  endtask

  // Reference code; int division truncates toward zero like the converter
  function automatic int expect_code(input int d, input int gs, input int rm, input int ext);
    int c;
    c = (d * (gs != 0 ? 4096 : 8192)) / (rm == 0 ? 16384 : rm == 1 ? 8192 : ext);
    if (c > 2047) c = 2047;
    if (c < -2048) c = -2048;
    return c;
  endfunction

  // Straps change only at group starts, so in-flight results of old groups go unchecked
  task automatic convert(input int grp);
    int p, n, c, g, i;
    @(negedge clock);
    p = int'($urandom_range(65535)) - 32768;
    n = ($urandom_range(1) != 0) ? p - int'($urandom_range(400)) :
                                   int'($urandom_range(65535)) - 32768;
    if (n < -32768) n = -32768;
    ain_pos = 16'(p);
    ain_neg = 16'(n);
    input_gain_stage = grp[0];
    ref_mode = 2'(grp / 2);
    ext_ref = 16'(700 + grp * 2900);
    hi_cyc = 8'(2 + grp % 4);
    lo_cyc = (grp == 5) ? 8'h1e : 8'h3;
    for (i = 0; i < 100 && n_edges == 16'(seen); i++) @(posedge clock);
    if (n_edges == 16'(seen)) begin
      bad("no edge");
      give_verdict();
    end
    seen++;
    if (exp_q.size() >= 3) begin
      c = exp_q.pop_front();
      g = grp_q.pop_front();
      if (g == grp) begin
        compares++;
        if (cap_word !== 12'(c) ||
            cap_flag !== (c == 2047 || c == -2048)) bad("result");
      end
    end
    exp_q.push_back(expect_code(p - n, grp % 2, grp / 2, int'(ext_ref)));
    grp_q.push_back(grp);
    for (i = 0; i < 20 && conv_clk !== 1'b0; i++) @(posedge clock);
    if (conv_clk !== 1'b0) begin
      bad("clock stuck high");
      give_verdict();
    end
  endtask

  initial begin
    void'($urandom(94889));
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    run = 1'b1;
    // Every gain and reference setting, varied duty, one slow group
    for (int grp = 0; grp < 8; grp++) begin
      repeat (10) convert(grp);
    end
    run = 1'b0;
    // Clock stopped: refresh pulses once per idle interval
    ticks = 0;
    repeat (180) begin
      @(negedge clock);
      if (refresh_tick === 1'b1) ticks++;
    end
    compares++;
    if (ticks != 3) bad("refresh count");
    give_verdict();
  end
endmodule
`default_nettype wire
